// ==== rtl/splb_regs.sv ====
// Configuration, error capture and status register bank of slave port 0.
`timescale 1ns/1ps
module splb_regs #(
   parameter bit WIDE_MODE = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Control register port.
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [5:0]  reg_idx,
   input  wire logic [31:0] reg_wdata,
   output logic [31:0]      reg_rdata,
   // Command observed on the slave port.
   input  wire logic        cmd_valid,
   input  wire logic [35:0] cmd_addr,
   input  wire logic [3:0]  cmd_size,
   input  wire logic [2:0]  cmd_type,
   input  wire logic        cmd_rnw,
   input  wire logic [1:0]  cmd_mid,
   input  wire logic [1:0]  cmd_mwidth,
   input  wire logic        cmd_lock_error,
   input  wire logic [15:0] cmd_byte_en,
   input  wire logic        cmd_addr_miss,
   // Queue and master events.
   input  wire logic [13:0] queue_events,
   input  wire logic [3:0]  mirq_propagate,
   input  wire logic [3:0]  mwr_err_posted,
   // Configuration, queue reset pulses and interrupt status out to the port logic.
   output logic [2:0]       write_master_burst_threshold,
   output logic             locked_transfer_enable,
   output logic             read_addr_pipeline_enable,
   output logic             write_addr_pipeline_enable,
   output logic             write_posting_enable,
   output logic [6:0]       queue_reset,
   output logic             xbar_isr_cfg_err,
   output logic             xbar_isr_fifo_err
);
   initial begin
      if (WIDE_MODE !== 1'b0 && WIDE_MODE !== 1'b1)
         $error("WIDE_MODE must be 0 or 1.");
   end

   logic [31:0] config_reg;
   logic [3:0]  addr_upper_reg;
   logic [31:0] addr_lower_reg;
   logic [31:0] qual_reg;
   logic [31:0] flags_reg;
   logic [3:0]  mirq_reg;
   logic [31:0] sniff_cmd_reg;
   logic [31:0] sniff_addr_reg;
   logic [6:0]  queue_reset_reg;

   cmd_if cmd ();
   assign cmd.valid = cmd_valid;
   assign cmd.addr = cmd_addr;
   assign cmd.size = cmd_size;
   assign cmd.xtype = cmd_type;
   assign cmd.rnw = cmd_rnw;
   assign cmd.mid = cmd_mid;
   assign cmd.mwidth = cmd_mwidth;
   assign cmd.lock_error = cmd_lock_error;
   assign cmd.byte_en = cmd_byte_en;
   assign cmd.addr_miss = cmd_addr_miss;

   cmd_checker u_check (
      .cmd         (cmd),
      .chk_disable (config_reg[splb_regs_pkg::CFG_CHKDIS]),
      .post_enable (config_reg[splb_regs_pkg::CFG_POSTING]),
      .sniff_cmd   (sniff_cmd_reg),
      .sniff_addr  (sniff_addr_reg)
   );

   function automatic logic hit(input logic [5:0] idx, input logic [5:0] target);
      hit = (idx == target);
   endfunction

   logic wr_cfg;
   logic wr_qual;
   logic wr_flags;
   logic wr_mirq;
   logic wr_qrst;
   logic wr_scmd;
   logic wr_saddr;
   assign wr_cfg = reg_wr && hit(reg_idx, splb_regs_pkg::IDX_CONFIG);
   assign wr_qual = reg_wr && hit(reg_idx, splb_regs_pkg::IDX_QUAL_STATUS);
   assign wr_flags = reg_wr && hit(reg_idx, splb_regs_pkg::IDX_FLAGS);
   assign wr_mirq = reg_wr && hit(reg_idx, splb_regs_pkg::IDX_MIRQ);
   assign wr_qrst = reg_wr && hit(reg_idx, splb_regs_pkg::IDX_WIDTH_QRST);
   assign wr_scmd = reg_wr && hit(reg_idx, splb_regs_pkg::IDX_SNIFF_CMD);
   assign wr_saddr = reg_wr && hit(reg_idx, splb_regs_pkg::IDX_SNIFF_ADDR);

   // Error events and sniffer hits that capture qualifiers and address.
   logic addr_err_ev;
   logic capture_ev;
   logic capture_ok;
   assign addr_err_ev = cmd.valid && cmd.addr_miss
                        && config_reg[splb_regs_pkg::CFG_AERR];
   assign capture_ev = addr_err_ev || cmd.illegal || cmd.post_err || cmd.sniff_hit;
   // A write to the status register in the same cycle clears it; the new event still lands.
   assign capture_ok = !config_reg[splb_regs_pkg::CFG_HOLD]
                       || !qual_reg[splb_regs_pkg::SESR_VALID] || wr_qual;

   // Configuration register; write pipelining cannot survive with posting off.
   logic [31:0] cfg_next;
   always_comb begin
      cfg_next = reg_wdata & splb_regs_pkg::CFG_IMPL_MASK;
      if (!cfg_next[splb_regs_pkg::CFG_POSTING])
         cfg_next[splb_regs_pkg::CFG_WR_PIPE] = 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         config_reg <= splb_regs_pkg::CFG_RESET;
      end else if (wr_cfg) begin
         config_reg <= cfg_next;
      end
   end

   // Qualifier capture and address capture share the same update condition.
   logic [31:0] qual_next;
   always_comb begin
      qual_next = '0;
      qual_next[splb_regs_pkg::SESR_VALID] = 1'b1;
      qual_next[splb_regs_pkg::SESR_LOCK_ERROR] = cmd.lock_error;
      qual_next[27:26] = cmd.mid;
      qual_next[25:24] = cmd.mwidth;
      qual_next[23:21] = cmd.xtype;
      qual_next[20] = cmd.rnw;
      qual_next[19:16] = cmd.size;
      qual_next[15:0] = cmd.byte_en;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qual_reg <= '0;
         addr_upper_reg <= '0;
         addr_lower_reg <= '0;
      end else if (capture_ev && capture_ok) begin
         qual_reg <= qual_next;
         addr_upper_reg <= cmd_addr[35:32];
         addr_lower_reg <= cmd_addr[31:0];
      end else if (wr_qual) begin
         qual_reg <= '0;
         addr_upper_reg <= '0;
         addr_lower_reg <= '0;
      end
   end

   // Sticky flags: a new event wins over a write-one clear in the same cycle.
   logic [31:0] flag_set;
   always_comb begin
      flag_set = '0;
      flag_set[splb_regs_pkg::FL_POSTERR] = cmd.post_err;
      flag_set[splb_regs_pkg::FL_ILLEGAL] = cmd.illegal;
      flag_set[splb_regs_pkg::FL_ADDRERR] = addr_err_ev;
      flag_set[13:0] = queue_events;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= '0;
      end else begin
         flags_reg <= (flags_reg & ~(wr_flags ? reg_wdata : 32'h0000_0000)) | flag_set;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mirq_reg <= '0;
      end else begin
         mirq_reg <= (mirq_reg & ~(wr_mirq ? reg_wdata[3:0] : 4'h0))
                     | mirq_propagate | mwr_err_posted;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sniff_cmd_reg <= '0;
         sniff_addr_reg <= '0;
      end else begin
         if (wr_scmd) sniff_cmd_reg <= reg_wdata;
         if (wr_saddr) sniff_addr_reg <= reg_wdata;
      end
   end

   // The lowest documented bit of the group resets queue 0, so the order is reversed.
   logic [6:0] qrst_next;
   always_comb begin
      qrst_next = '0;
      for (int unsigned q = 0; q < splb_regs_pkg::NUM_QUEUES; q++) begin
         qrst_next[q] = wr_qrst && reg_wdata[splb_regs_pkg::NUM_QUEUES - 1 - q];
      end
   end

   // Queue resets are one-cycle pulses and never stored as readable state.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         queue_reset_reg <= '0;
      end else begin
         queue_reset_reg <= qrst_next;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xbar_isr_cfg_err <= 1'b0;
         xbar_isr_fifo_err <= 1'b0;
      end else begin
         xbar_isr_cfg_err <= |flags_reg[31:29];
         xbar_isr_fifo_err <= |flags_reg[13:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         write_master_burst_threshold <= splb_regs_pkg::CFG_RESET[splb_regs_pkg::CFG_THW_LO +: 3];
         locked_transfer_enable <= splb_regs_pkg::CFG_RESET[splb_regs_pkg::CFG_LOCK];
         read_addr_pipeline_enable <= splb_regs_pkg::CFG_RESET[splb_regs_pkg::CFG_RD_PIPE];
         write_addr_pipeline_enable <= splb_regs_pkg::CFG_RESET[splb_regs_pkg::CFG_WR_PIPE];
         write_posting_enable <= splb_regs_pkg::CFG_RESET[splb_regs_pkg::CFG_POSTING];
      end else begin
         write_master_burst_threshold <= config_reg[splb_regs_pkg::CFG_THW_LO +: 3];
         locked_transfer_enable <= config_reg[splb_regs_pkg::CFG_LOCK];
         read_addr_pipeline_enable <= config_reg[splb_regs_pkg::CFG_RD_PIPE];
         write_addr_pipeline_enable <= config_reg[splb_regs_pkg::CFG_WR_PIPE]
                                       && config_reg[splb_regs_pkg::CFG_POSTING];
         write_posting_enable <= config_reg[splb_regs_pkg::CFG_POSTING];
      end
   end
   assign queue_reset = queue_reset_reg;

   logic [31:0] rd_mux;
   always_comb begin
      case (reg_idx)
         splb_regs_pkg::IDX_CONFIG: rd_mux = config_reg;
         splb_regs_pkg::IDX_ADDR_UPPER: rd_mux = {28'h0000000, addr_upper_reg};
         splb_regs_pkg::IDX_ADDR_LOWER: rd_mux = addr_lower_reg;
         splb_regs_pkg::IDX_QUAL_STATUS: rd_mux = qual_reg;
         splb_regs_pkg::IDX_FLAGS: rd_mux = flags_reg;
         splb_regs_pkg::IDX_MIRQ: rd_mux = {28'h0000000, mirq_reg};
         splb_regs_pkg::IDX_STATE_OBS: rd_mux = 32'h0000_0000;
         splb_regs_pkg::IDX_WIDTH_QRST: rd_mux = {WIDE_MODE, 31'h00000000};
         splb_regs_pkg::IDX_SNIFF_CMD: rd_mux = sniff_cmd_reg;
         splb_regs_pkg::IDX_SNIFF_ADDR: rd_mux = sniff_addr_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end
endmodule

// ==== inc/splb_regs_pkg.sv ====
// Package with register indices, field positions and reset values of the slave port bank.
package splb_regs_pkg;
   localparam int unsigned REG_AW = 6;
   // Register indices on the control register port.
   localparam logic [5:0] IDX_CONFIG = 6'h34;
   localparam logic [5:0] IDX_ADDR_UPPER = 6'h36;
   localparam logic [5:0] IDX_ADDR_LOWER = 6'h37;
   localparam logic [5:0] IDX_QUAL_STATUS = 6'h38;
   localparam logic [5:0] IDX_FLAGS = 6'h39;
   localparam logic [5:0] IDX_MIRQ = 6'h3A;
   localparam logic [5:0] IDX_STATE_OBS = 6'h3B;
   localparam logic [5:0] IDX_WIDTH_QRST = 6'h3C;
   localparam logic [5:0] IDX_SNIFF_CMD = 6'h3D;
   localparam logic [5:0] IDX_SNIFF_ADDR = 6'h3E;

   // Big-endian bit numbers are converted: documented bit b sits at [31-b].
   localparam int unsigned CFG_HOLD = 31;        // bit 0
   localparam int unsigned CFG_THW_LO = 8;       // bits 21:23
   localparam int unsigned CFG_LOCK = 6;         // bit 25
   localparam int unsigned CFG_RD_PIPE = 5;      // bit 26
   localparam int unsigned CFG_WR_PIPE = 4;      // bit 27
   localparam int unsigned CFG_POSTING = 3;      // bit 28
   localparam int unsigned CFG_MUST1 = 2;        // bit 29
   localparam int unsigned CFG_AERR = 1;         // bit 30
   localparam int unsigned CFG_CHKDIS = 0;       // bit 31
   localparam logic [31:0] CFG_RESET = 32'h8000_036C;
   localparam logic [31:0] CFG_IMPL_MASK = 32'h8000_077F;

   localparam int unsigned FL_POSTERR = 31;      // bit 0
   localparam int unsigned FL_ILLEGAL = 30;      // bit 1
   localparam int unsigned FL_ADDRERR = 29;      // bit 2
   localparam int unsigned NUM_QUEUES = 7;       // queue flags in bits 18..31

   localparam int unsigned SESR_VALID = 31;
   localparam int unsigned SESR_LOCK_ERROR = 30;

   localparam logic [2:0] THW_SINGLE = 3'h0;
   localparam logic [2:0] THW_MAX = 3'h4;
   localparam logic [2:0] TYPE_MEMORY = 3'h0;
   localparam int unsigned MIRQ_MASTERS = 4;
   localparam int unsigned ISR_CFG_BIT = 3;
   localparam int unsigned ISR_FIFO_BIT = 7;
endpackage

// ==== inc/cmd_if.sv ====
// Interface carrying one observed slave-port command between the bank and its checker.
`timescale 1ns/1ps
interface cmd_if;
   logic        valid;
   logic [35:0] addr;
   logic [3:0]  size;
   logic [2:0]  xtype;
   logic        rnw;
   logic [1:0]  mid;
   logic [1:0]  mwidth;
   logic        lock_error;
   logic [15:0] byte_en;
   logic        addr_miss;
   logic        illegal;
   logic        post_err;
   logic        sniff_hit;
   modport src (output valid, addr, size, xtype, rnw, mid, mwidth, lock_error, byte_en);
   modport chk (input valid, addr, size, xtype, rnw, mid, mwidth, lock_error, byte_en,
                output illegal, post_err, sniff_hit);
   modport dst (input valid, addr, size, xtype, rnw, mid, mwidth, lock_error, byte_en,
                illegal, post_err, sniff_hit);
endinterface

// ==== rtl/cmd_checker.sv ====
// Combinational command legality check and sniffer match for the slave port.
`timescale 1ns/1ps
module cmd_checker (
   cmd_if.chk         cmd,
   input  wire logic  chk_disable,
   input  wire logic  post_enable,
   input  wire logic [31:0] sniff_cmd,
   input  wire logic [31:0] sniff_addr
);
   function automatic logic size_legal(input logic [3:0] s);
      case (s)
         4'h0, 4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'hC: size_legal = 1'b1;
         default: size_legal = 1'b0;
      endcase
   endfunction

   logic en_match;
   always_comb begin
      // Sniffer fields, big-endian: enable 0, size 4:7, rnw 8, size_en 25, rnw_en 26, addr_en 31.
      en_match = sniff_cmd[31];
      if (sniff_cmd[6] && (sniff_cmd[27:24] != cmd.size)) en_match = 1'b0;
      if (sniff_cmd[5] && (sniff_cmd[23] != cmd.rnw)) en_match = 1'b0;
      if (sniff_cmd[0] && (sniff_addr != cmd.addr[31:0])) en_match = 1'b0;
   end

   // Only single transfers pass when posting is off; the check is skipped when disabled.
   assign cmd.illegal = cmd.valid && !chk_disable && !size_legal(cmd.size);
   assign cmd.post_err = cmd.valid && !chk_disable && !post_enable
                         && (cmd.size != 4'h0);
   assign cmd.sniff_hit = cmd.valid && en_match;
endmodule

// ==== sim/splb_regs_props.sv ====
// Concurrent checks on the ports of the slave port register bank.
`timescale 1ns/1ps
module splb_regs_props #(
   parameter bit WIDE_MODE = 1'b1
) (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [5:0]  reg_idx,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic [13:0] queue_events,
   input wire logic [2:0]  write_master_burst_threshold,
   input wire logic        locked_transfer_enable,
   input wire logic        read_addr_pipeline_enable,
   input wire logic        write_addr_pipeline_enable,
   input wire logic        write_posting_enable,
   input wire logic [6:0]  queue_reset,
   input wire logic        xbar_isr_fifo_err
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic       cfg_wr;
   logic       qr_wr;
   logic [6:0] qr_exp;
   assign cfg_wr = reg_wr && reg_idx == splb_regs_pkg::IDX_CONFIG;
   assign qr_wr = reg_wr && reg_idx == splb_regs_pkg::IDX_WIDTH_QRST;
   // The lowest documented bit resets queue 0, so the vector order is reversed.
   assign qr_exp = {reg_wdata[0], reg_wdata[1], reg_wdata[2], reg_wdata[3],
                    reg_wdata[4], reg_wdata[5], reg_wdata[6]};
   property p_thr;
      cfg_wr |-> ##2 write_master_burst_threshold == $past(reg_wdata[10:8], 2);
   endproperty
   a_thr: assert property (p_thr) else $error("threshold output wrong");
   property p_lock;
      cfg_wr |-> ##2 locked_transfer_enable == $past(reg_wdata[6], 2);
   endproperty
   a_lock: assert property (p_lock) else $error("lock enable wrong");
   property p_read_addr_pipeline_enable;
      cfg_wr |-> ##2 read_addr_pipeline_enable == $past(reg_wdata[5], 2);
   endproperty
   a_read_addr_pipeline_enable: assert property (p_read_addr_pipeline_enable) else $error("read pipeline wrong");
   property p_write_addr_pipeline_enable;
      cfg_wr |-> ##2 write_addr_pipeline_enable == $past(reg_wdata[4] && reg_wdata[3], 2);
   endproperty
   a_write_addr_pipeline_enable: assert property (p_write_addr_pipeline_enable) else $error("write pipeline wrong");
   property p_write_posting_enable;
      cfg_wr |-> ##2 write_posting_enable == $past(reg_wdata[3], 2);
   endproperty
   a_write_posting_enable: assert property (p_write_posting_enable) else $error("posting enable wrong");
   property p_obs;
      reg_rd && reg_idx == splb_regs_pkg::IDX_STATE_OBS |=> reg_rdata == 32'h0;
   endproperty
   a_obs: assert property (p_obs) else $error("state register not zero");
   property p_width;
      reg_rd && reg_idx == splb_regs_pkg::IDX_WIDTH_QRST |=> reg_rdata == {WIDE_MODE, 31'h0};
   endproperty
   a_width: assert property (p_width) else $error("width register wrong");
   property p_qrst;
      qr_wr |=> queue_reset == $past(qr_exp);
   endproperty
   a_qrst: assert property (p_qrst) else $error("queue reset pulse wrong");
   property p_qidle;
      !qr_wr |=> queue_reset == 7'h00;
   endproperty
   a_qidle: assert property (p_qidle) else $error("stray queue reset");
   property p_fifo;
      |queue_events |-> ##2 xbar_isr_fifo_err;
   endproperty
   a_fifo: assert property (p_fifo) else $error("queue interrupt missing");
   c_cfg: cover property (cfg_wr);
   c_qall: cover property (qr_wr && reg_wdata[6:0] == 7'h7F);
   c_ev: cover property (|queue_events);
endmodule

// ==== sim/cmd_master.sv ====
// Behavioural bus master side: issues commands and queue or interrupt events.
`timescale 1ns/1ps
module cmd_master (
   input  wire logic   clk,
   output logic        cmd_valid,
   output logic [35:0] cmd_addr,
   output logic [3:0]  cmd_size,
   output logic [2:0]  cmd_type,
   output logic        cmd_rnw,
   output logic [1:0]  cmd_mid,
   output logic [1:0]  cmd_mwidth,
   output logic        cmd_lock_error,
   output logic [15:0] cmd_byte_en,
   output logic        cmd_addr_miss,
   output logic [13:0] queue_events,
   output logic [3:0]  mirq_propagate,
   output logic [3:0]  mwr_err_posted
);
   initial begin
      {cmd_valid, cmd_addr_miss, queue_events, mirq_propagate, mwr_err_posted} = '0;
      {cmd_addr, cmd_size, cmd_type, cmd_rnw} = '1;
      {cmd_mid, cmd_mwidth, cmd_lock_error, cmd_byte_en} = '1;
   end
   // Qualifiers mean nothing without the strobe, so they are inverted between commands.
   task automatic send(input logic [3:0] size, input logic [35:0] addr, input logic miss);
      @(negedge clk);
      {cmd_valid, cmd_addr_miss} = {1'b1, miss};
      {cmd_addr, cmd_size, cmd_type, cmd_rnw} = {addr, size, 3'h0, 1'b1};
      {cmd_mid, cmd_mwidth, cmd_lock_error, cmd_byte_en} = {2'h1, 2'h2, 1'b1, 16'hA5C3};
      @(negedge clk);
      {cmd_valid, cmd_addr_miss} = 2'h0;
      {cmd_addr, cmd_size, cmd_type, cmd_rnw} = ~{cmd_addr, cmd_size, cmd_type, cmd_rnw};
      {cmd_mid, cmd_mwidth, cmd_lock_error, cmd_byte_en} =
         ~{cmd_mid, cmd_mwidth, cmd_lock_error, cmd_byte_en};
   endtask
   task automatic ev(input logic [13:0] q, input logic [3:0] p, input logic [3:0] w);
      @(negedge clk);
      {queue_events, mirq_propagate, mwr_err_posted} = {q, p, w};
      @(negedge clk);
      {queue_events, mirq_propagate, mwr_err_posted} = '0;
   endtask
endmodule

// ==== sim/splb_regs_test.sv ====
// Self-checking bench for the slave port register bank.
`timescale 1ns/1ps
module splb_regs_test;
   localparam bit WIDE_MODE = 1'b1;
   // Qualifier word for the fields the master model sends, size 0, valid set.
   localparam logic [31:0] QBASE = 32'hC610_A5C3;
   logic        clk, rst_n, reg_wr, reg_rd, cmd_valid, cmd_rnw, cmd_lock_error, cmd_addr_miss;
   logic        locked_transfer_enable, read_addr_pipeline_enable, write_addr_pipeline_enable;
   logic        write_posting_enable, xbar_isr_cfg_err, xbar_isr_fifo_err;
   logic [1:0]  cmd_mid, cmd_mwidth;
   logic [2:0]  cmd_type, write_master_burst_threshold;
   logic [3:0]  cmd_size, mirq_propagate, mwr_err_posted;
   logic [5:0]  reg_idx;
   logic [6:0]  queue_reset;
   logic [13:0] queue_events;
   logic [15:0] cmd_byte_en;
   logic [31:0] reg_wdata, reg_rdata;
   logic [35:0] cmd_addr;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   splb_regs #(.WIDE_MODE(WIDE_MODE)) dut (.clk, .rst_n, .reg_wr, .reg_rd, .reg_idx, .reg_wdata,
      .reg_rdata, .cmd_valid, .cmd_addr, .cmd_size, .cmd_type, .cmd_rnw, .cmd_mid, .cmd_mwidth,
      .cmd_lock_error, .cmd_byte_en, .cmd_addr_miss, .queue_events, .mirq_propagate,
      .mwr_err_posted, .write_master_burst_threshold, .locked_transfer_enable,
      .read_addr_pipeline_enable, .write_addr_pipeline_enable, .write_posting_enable,
      .queue_reset, .xbar_isr_cfg_err, .xbar_isr_fifo_err);
   cmd_master m (.clk, .cmd_valid, .cmd_addr, .cmd_size, .cmd_type, .cmd_rnw, .cmd_mid,
      .cmd_mwidth, .cmd_lock_error, .cmd_byte_en, .cmd_addr_miss, .queue_events,
      .mirq_propagate, .mwr_err_posted);
   task automatic complete_run();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] idx, input logic [31:0] data);
      @(negedge clk);
      {reg_wr, reg_idx, reg_wdata} = {1'b1, idx, data};
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
      @(negedge clk);
      {reg_rd, reg_idx} = {1'b1, idx};
      @(negedge clk);
      reg_rd = 1'b0;
      chk(reg_rdata, exp);
   endtask
   task automatic t_reset();
      rd(6'h34, 32'h8000_036C);
      chk({25'h0, locked_transfer_enable, read_addr_pipeline_enable, write_addr_pipeline_enable,
           write_posting_enable, write_master_burst_threshold}, 32'h6B);
      wr(6'h3B, 32'hFFFF_FFFF);
      rd(6'h3B, 32'h0);
      rd(6'h3C, 32'h8000_0000);
      rd(6'h36, 32'h0);
      rd(6'h38, 32'h0);
   endtask
   task automatic t_cfg();
      wr(6'h34, 32'hFFFF_FFFF);
      rd(6'h34, 32'h8000_077F);
      for (int c = 0; c < 5; c++) begin
         wr(6'h34, 32'h0000_000C | (32'(c) << 8));
         @(negedge clk);
         chk({29'h0, write_master_burst_threshold}, 32'(c));
      end
      wr(6'h34, 32'h0000_0014);
      rd(6'h34, 32'h0000_0004);
      chk({31'h0, write_addr_pipeline_enable}, 32'h0);
      wr(6'h34, 32'h0000_001C);
      rd(6'h34, 32'h0000_001C);
      chk({25'h0, locked_transfer_enable, read_addr_pipeline_enable, write_addr_pipeline_enable,
           write_posting_enable, write_master_burst_threshold}, 32'h18);
   endtask
   task automatic t_cmd();
      logic ill;
      wr(6'h34, 32'h0000_000C);
      for (int s = 0; s < 16; s++) begin
         ill = !(s inside {[0:3], [10:12]});
         m.send(4'(s), 36'h9_1234_5678, 1'b0);
         rd(6'h39, {1'b0, ill, 30'h0});
         if (ill) chk({31'h0, xbar_isr_cfg_err}, 32'h1);
         wr(6'h39, 32'hFFFF_FFFF);
      end
      rd(6'h38, QBASE | 32'h000F_0000);
      rd(6'h36, 32'h0000_0009);
      rd(6'h37, 32'h1234_5678);
   endtask
   task automatic t_post_addr();
      wr(6'h34, 32'h0000_0004);
      m.send(4'hA, 36'h0, 1'b0);
      rd(6'h39, 32'h8000_0000);
      wr(6'h39, 32'hFFFF_FFFF);
      wr(6'h34, 32'h0000_0005);
      m.send(4'hA, 36'h0, 1'b0);
      m.send(4'h5, 36'h0, 1'b0);
      rd(6'h39, 32'h0);
      wr(6'h34, 32'h0000_000C);
      m.send(4'h0, 36'h0, 1'b1);
      rd(6'h39, 32'h0);
      wr(6'h34, 32'h0000_000E);
      m.send(4'h0, 36'h0, 1'b1);
      rd(6'h39, 32'h2000_0000);
      wr(6'h39, 32'h0000_0000);
      rd(6'h39, 32'h2000_0000);
      wr(6'h39, 32'h2000_0000);
      rd(6'h39, 32'h0);
   endtask
   task automatic t_hold_sniff();
      wr(6'h38, 32'h0);
      wr(6'h34, 32'h8000_000C);
      m.send(4'h5, 36'h1_0000_0001, 1'b0);
      m.send(4'h6, 36'h2_0000_0002, 1'b0);
      rd(6'h38, QBASE | 32'h0005_0000);
      rd(6'h37, 32'h0000_0001);
      wr(6'h38, 32'h0);
      rd(6'h38, 32'h0);
      rd(6'h36, 32'h0);
      rd(6'h37, 32'h0);
      wr(6'h34, 32'h0000_000C);
      wr(6'h3E, 32'h0000_0ABC);
      wr(6'h3D, 32'h8000_0001);
      m.send(4'h0, 36'h0_0000_0ABC, 1'b0);
      rd(6'h38, QBASE);
      rd(6'h37, 32'h0000_0ABC);
      rd(6'h39, 32'h4000_0000);
      wr(6'h39, 32'hFFFF_FFFF);
   endtask
   task automatic t_events();
      m.ev(14'h2001, 4'h1, 4'h8);
      rd(6'h39, 32'h0000_2001);
      chk({31'h0, xbar_isr_fifo_err}, 32'h1);
      wr(6'h39, 32'h0000_0001);
      rd(6'h39, 32'h0000_2000);
      rd(6'h3A, 32'h0000_0009);
      wr(6'h3A, 32'h0000_0008);
      rd(6'h3A, 32'h0000_0001);
      wr(6'h3C, 32'h0000_0040);
      chk({25'h0, queue_reset}, 32'h01);
      wr(6'h3C, 32'h0000_007F);
      chk({25'h0, queue_reset}, 32'h7F);
      rd(6'h3C, 32'h8000_0000);
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // The whole run needs well under a thousand cycles.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      {rst_n, reg_wr, reg_rd, reg_idx, reg_wdata} = '0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_cfg();
      t_cmd();
      t_post_addr();
      t_hold_sniff();
      t_events();
      complete_run();
   end
endmodule
bind splb_regs splb_regs_props #(.WIDE_MODE(WIDE_MODE)) props (.clk, .rst_n, .reg_wr,
   .reg_rd, .reg_idx, .reg_wdata, .reg_rdata, .queue_events, .write_master_burst_threshold,
   .locked_transfer_enable, .read_addr_pipeline_enable, .write_addr_pipeline_enable,
   .write_posting_enable, .queue_reset, .xbar_isr_fifo_err);
